/* File: logic/atatf_buf2.v */
`timescale 1ns/10ps
module atatf_buf2 #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count != 2'h2;
  assign out_valid = count != 2'h0;
  assign out_data = mem[rd_ptr];
  always @(posedge clock) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: logic/atatf_decode.v */
`timescale 1ns/10ps
`include "atatf_consts.vh"
// Summary of operation
// - Register cycles answered while DEV bit equals own device number, or by device 0 for an absent device 1 while idle.
// - Cylinder-high read returns that register when idle, status when busy.
// - Device/head write when idle stores value and updates selection.
// - Shadow writes with busy 0 and data-request 1 are discarded.
// - Device/head read returns register when idle, status when busy.
// - Idle command write stores opcode, starts it, clears interrupt pending.
// - Command write while busy clears pending if reset-device supported.
// - Command-block status read drives status and clears interrupt pending; alternate status read does not clear it.
// - DMA acknowledge with request released ignores every strobe.
// - DMA acknowledge, request negated, no chip select: strobe ignored.
// - DMA acknowledge and request, busy or data-request: one word moves; a write into a full buffer is dropped.
// - Chip select during DMA acknowledge: strobe ignored.
// - Absent device 1 answered: device control written, nIEN and SRST act.
// - Absent device 1 answered: alternate status reads 00H.
// - Absent device 1 answered: features writes stored.
// - Absent device 1 answered: error register returned.
// - Absent device 1 answered: sector-count writes stored.
// - Absent device 1: commands stored, only diagnostics acted on; status 00H.
module atatf_decode #(
  parameter DEV_NUM = 0,
  parameter HAS_DEV_RESET = 1,
  parameter DATA_WIDTH = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Host pins, one-cycle strobes already synchronous
  input wire cs0_n,
  input wire cs1_n,
  input wire [2:0] da,
  input wire rd_strobe,
  input wire wr_strobe,
  input wire dmack_n,
  input wire [DATA_WIDTH-1:0] host_wdata,
  output reg [DATA_WIDTH-1:0] host_rdata,
  output reg rdata_valid,
  // DMA request pin
  input wire dmarq_req,
  output wire dmarq_out,
  output wire dmarq_oe,
  // Device state from the core
  input wire busy,
  input wire drq,
  input wire [7:0] status,
  input wire [7:0] error,
  input wire dev1_absent,
  input wire intrq_set,
  // DMA write words toward the core
  output wire dma_wvalid,
  input wire dma_wready,
  output wire [DATA_WIDTH-1:0] dma_wdata,
  output wire dma_stall,
  // DMA read words from the core
  input wire [DATA_WIDTH-1:0] dma_rdata,
  output reg dma_rd_pulse,
  // Command and control outputs
  output reg cmd_start,
  output reg [7:0] cmd_opcode,
  output reg intrq_pending,
  output wire nien,
  output wire srst,
  output wire selected,
  output wire [7:0] features,
  output wire [7:0] sector_count,
  output wire [7:0] sector_number,
  output wire [7:0] cyl_low,
  output wire [7:0] cyl_high,
  output wire [7:0] dev_head
);
  reg [7:0] regs [0:7];
  reg [2:0] wslot;
  reg wen;
  reg [7:0] rval;
  reg rhit;
  reg next_pending;
  reg next_start;
  wire cmd_blk;
  wire ctl_blk;
  wire [3:0] idx;
  wire dma_in_ready;
  wire dma_ack = !dmack_n;
  wire strobe = rd_strobe || wr_strobe;
  wire own_dev = regs[`ATATF_REG_DEVHEAD][`ATATF_DEV_BIT] == DEV_NUM[0];
  // Device 0 standing in for a missing device 1 only while idle
  wire proxy = (DEV_NUM == 0) && dev1_absent && !own_dev && !busy && !drq;
  wire idle = !busy && !drq;
  wire reg_cycle = dmack_n && strobe && (own_dev || proxy);
  wire status_rd = reg_cycle && rd_strobe && cmd_blk && idx == `ATATF_IDX_CMD_STAT;

  // Selected device always drives the request pin at the dmarq_req level; others drive it only while dmarq_req is set
  assign dmarq_oe = dmarq_req || own_dev;
  assign dmarq_out = dmarq_req;
  assign selected = own_dev;
  assign nien = regs[`ATATF_REG_CTRL][`ATATF_NIEN_BIT];
  assign srst = regs[`ATATF_REG_CTRL][`ATATF_SRST_BIT];
  assign features = regs[`ATATF_REG_FEAT];
  assign sector_count = regs[`ATATF_REG_SECCNT];
  assign sector_number = regs[`ATATF_REG_SECNUM];
  assign cyl_low = regs[`ATATF_REG_CYLLO];
  assign cyl_high = regs[`ATATF_REG_CYLHI];
  assign dev_head = regs[`ATATF_REG_DEVHEAD];

  function [2:0] shadow_slot;
    input [3:0] i;
    begin
      case (i)
        `ATATF_IDX_FEAT_ERR: shadow_slot = `ATATF_REG_FEAT;
        `ATATF_IDX_SECCNT: shadow_slot = `ATATF_REG_SECCNT;
        `ATATF_IDX_SECNUM: shadow_slot = `ATATF_REG_SECNUM;
        `ATATF_IDX_CYLLO: shadow_slot = `ATATF_REG_CYLLO;
        `ATATF_IDX_CYLHI: shadow_slot = `ATATF_REG_CYLHI;
        `ATATF_IDX_DEVHEAD: shadow_slot = `ATATF_REG_DEVHEAD;
        `ATATF_IDX_CMD_STAT: shadow_slot = `ATATF_REG_CMD;
        default: shadow_slot = `ATATF_REG_CTRL;
      endcase
    end
  endfunction

  atatf_index u_index (
    .cs0_n(cs0_n),
    .cs1_n(cs1_n),
    .da(da),
    .cmd_blk(cmd_blk),
    .ctl_blk(ctl_blk),
    .idx(idx)
  );

  // DMA word path: no chip select, acknowledge and request active, busy or drq
  wire dma_cycle = dma_ack && dmarq_req && cs0_n && cs1_n && (busy || drq);
  // A full buffer raises dma_stall; a host word written while it is full is dropped
  assign dma_stall = !dma_in_ready;

  atatf_buf2 #(
    .WIDTH(DATA_WIDTH)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(dma_cycle && wr_strobe),
    .in_ready(dma_in_ready),
    .in_data(host_wdata),
    .out_valid(dma_wvalid),
    .out_ready(dma_wready),
    .out_data(dma_wdata)
  );

  // Write decode
  always @* begin
    wen = 1'b0;
    wslot = shadow_slot(idx);
    next_pending = intrq_pending;
    next_start = 1'b0;
    if (reg_cycle && wr_strobe) begin
      if (ctl_blk && idx == `ATATF_IDX_CTRL_ALT) begin
        wen = 1'b1;
      end else if (cmd_blk && idx != `ATATF_IDX_DATA) begin
        if (proxy) begin
          wen = 1'b1;
          if (idx == `ATATF_IDX_CMD_STAT && host_wdata[7:0] == `ATATF_DIAG_OPCODE) begin
            next_start = 1'b1;
            next_pending = 1'b0;
          end
        end else if (idle) begin
          wen = 1'b1;
          if (idx == `ATATF_IDX_CMD_STAT) begin
            next_start = 1'b1;
            next_pending = 1'b0;
          end
        end else if (idx == `ATATF_IDX_CMD_STAT && HAS_DEV_RESET != 0) begin
          next_pending = 1'b0;
        end
        // Busy 0 with drq 1 falls through: write dropped
        // Busy 1 writes to other shadows are also dropped
      end
    end
  end

  // Read decode
  always @* begin
    rval = 8'h00;
    rhit = 1'b0;
    if (reg_cycle && rd_strobe) begin
      rhit = 1'b1;
      if (ctl_blk && idx == `ATATF_IDX_CTRL_ALT) begin
        rval = proxy ? `ATATF_ABSENT_READ : status;
      end else if (cmd_blk && idx == `ATATF_IDX_CMD_STAT) begin
        rval = proxy ? `ATATF_ABSENT_READ : status;
      end else if (cmd_blk && idx != `ATATF_IDX_DATA) begin
        if (busy) begin
          rval = status;
        end else if (idx == `ATATF_IDX_FEAT_ERR) begin
          rval = error;
        end else if (proxy && idx == `ATATF_IDX_DEVHEAD) begin
          rval = regs[`ATATF_REG_DEVHEAD] | (8'h01 << `ATATF_DEV_BIT);
        end else begin
          rval = regs[shadow_slot(idx)];
        end
      end else begin
        rhit = 1'b0;
      end
    end
  end

  integer k;
  always @(posedge clock) begin
    if (rst) begin
      for (k = 0; k < 8; k = k + 1) begin
        regs[k] <= `ATATF_REG_RST;
      end
      host_rdata <= {DATA_WIDTH{1'b0}};
      rdata_valid <= 1'b0;
      cmd_start <= 1'b0;
      cmd_opcode <= `ATATF_REG_RST;
      intrq_pending <= 1'b0;
      dma_rd_pulse <= 1'b0;
    end else begin
      if (wen) begin
        regs[wslot] <= host_wdata[7:0];
      end
      cmd_start <= next_start;
      if (next_start) begin
        cmd_opcode <= host_wdata[7:0];
      end
      dma_rd_pulse <= dma_cycle && rd_strobe;
      rdata_valid <= rhit || (dma_cycle && rd_strobe);
      if (dma_cycle && rd_strobe) begin
        host_rdata <= dma_rdata;
      end else if (rhit) begin
        host_rdata <= {{(DATA_WIDTH-8){1'b0}}, rval};
      end
      // A new request from the core beats a clear in the same cycle, so none is lost
      if (intrq_set) begin
        intrq_pending <= 1'b1;
      end else if (status_rd) begin
        intrq_pending <= 1'b0;
      end else begin
        intrq_pending <= next_pending;
      end
    end
  end
endmodule

/* File: logic/atatf_index.v */
`timescale 1ns/10ps
module atatf_index (
  // Host address pins
  input wire cs0_n,
  input wire cs1_n,
  input wire [2:0] da,
  // Decoded target
  output wire cmd_blk,
  output wire ctl_blk,
  output wire [3:0] idx
);
  // Only one chip select at a time names a register
  assign cmd_blk = !cs0_n && cs1_n;
  assign ctl_blk = cs0_n && !cs1_n;
  assign idx = {ctl_blk, da};
endmodule

/* File: shared/atatf_consts.vh */
`ifndef ATATF_CONSTS_VH
`define ATATF_CONSTS_VH
// Register index = {cs1 active, da2, da1, da0}
`define ATATF_IDX_DATA 4'h0
`define ATATF_IDX_FEAT_ERR 4'h1
`define ATATF_IDX_SECCNT 4'h2
`define ATATF_IDX_SECNUM 4'h3
`define ATATF_IDX_CYLLO 4'h4
`define ATATF_IDX_CYLHI 4'h5
`define ATATF_IDX_DEVHEAD 4'h6
`define ATATF_IDX_CMD_STAT 4'h7
`define ATATF_IDX_CTRL_ALT 4'he
// Register file slots
`define ATATF_REG_FEAT 3'h0
`define ATATF_REG_SECCNT 3'h1
`define ATATF_REG_SECNUM 3'h2
`define ATATF_REG_CYLLO 3'h3
`define ATATF_REG_CYLHI 3'h4
`define ATATF_REG_DEVHEAD 3'h5
`define ATATF_REG_CMD 3'h6
`define ATATF_REG_CTRL 3'h7
// Field positions
`define ATATF_DEV_BIT 4
`define ATATF_NIEN_BIT 1
`define ATATF_SRST_BIT 2
// Reset values, absent-device read value and diagnostic opcode
`define ATATF_REG_RST 8'h00
`define ATATF_ABSENT_READ 8'h00
`define ATATF_DIAG_OPCODE 8'h90
`endif

/* File: verif/atatf_decode_bench.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module atatf_decode_bench;
  logic clock, rst, busy, drq, dev1_absent, dmarq_req, dma_wready, intrq_set;
  logic [7:0] status, error;
  logic [15:0] dma_rdata;
  wire cs0_n, cs1_n, rd_strobe, wr_strobe, dmack_n, rdata_valid, dmarq_out, dmarq_oe, dma_wvalid, dma_stall;
  wire dma_rd_pulse, cmd_start, intrq_pending, nien, srst, selected;
  wire [2:0] da;
  wire [15:0] host_wdata, host_rdata, dma_wdata;
  wire [7:0] cmd_opcode, features, sector_count, sector_number, cyl_low, cyl_high, dev_head;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  atatf_decode i_atatf_decode (.*);
  atatf_host_model i_atatf_host_model (.*);
  task end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input [4:0] a, input [7:0] d);
    i_atatf_host_model.cyc(1'b0, 1'b0, a, {8'h00, d});
  endtask
  task rd(input [4:0] a, input [7:0] e);
    i_atatf_host_model.cyc(1'b1, 1'b0, a, 16'h0000);
    `CHK("rdata_valid", 1'b1, rdata_valid)
    `CHK("host_rdata", {8'h00, e}, host_rdata)
  endtask
  task pend;
    intrq_set = 1;
    @(negedge clock);
    intrq_set = 0;
    `CHK("intrq_pending", 1'b1, intrq_pending)
  endtask
  task dma(input r, input [4:0] a, input [15:0] d);
    i_atatf_host_model.cyc(r, 1'b1, a, d);
  endtask
  task t_regs;
    status = 8'h50;
    error = 8'h04;
    wr(5'h15, 8'h5a);
    rd(5'h15, 8'h5a);
    busy = 1;
    rd(5'h15, 8'h50);
    rd(5'h16, 8'h50);
    busy = 0;
    rd(5'h16, 8'h00);
    pend;
    wr(5'h17, 8'h20);
    `CHK("cmd_write", 10'h120, {intrq_pending, cmd_start, cmd_opcode})
    pend;
    rd(5'h17, 8'h50);
    `CHK("intrq_pending", 1'b0, intrq_pending)
    intrq_set = 1;
    rd(5'h17, 8'h50);
    intrq_set = 0;
    `CHK("pending_set_wins", 1'b1, intrq_pending)
    busy = 1;
    wr(5'h17, 8'h21);
    `CHK("busy_cmd", 10'h020, {intrq_pending, cmd_start, cmd_opcode})
    busy = 0;
    drq = 1;
    wr(5'h12, 8'h33);
    `CHK("sector_count", 8'h00, sector_count)
    drq = 0;
    wr(5'h12, 8'h44);
    `CHK("sector_count", 8'h44, sector_count)
  endtask
  task t_dma;
    busy = 1;
    dmarq_req = 1;
    dma(1'b0, 5'h00, 16'ha001);
    dma(1'b0, 5'h00, 16'ha002);
    `CHK("dma_stall", 1'b1, dma_stall)
    dma(1'b0, 5'h00, 16'ha003);
    dma_wready = 1;
    `CHK("dma_wdata", 16'ha001, dma_wdata)
    @(negedge clock);
    `CHK("dma_wdata", 16'ha002, dma_wdata)
    @(negedge clock);
    `CHK("dma_wvalid", 1'b0, dma_wvalid)
    dma_rdata = 16'hbeef;
    dma(1'b1, 5'h00, 16'h0000);
    `CHK("dma_rd_pulse", 1'b1, dma_rd_pulse)
    `CHK("dma_read", 17'h1beef, {rdata_valid, host_rdata})
    dma(1'b1, 5'h17, 16'h0000);
    `CHK("dma_cs", 2'b00, {dma_rd_pulse, rdata_valid})
    dmarq_req = 0;
    `CHK("dmarq_pin", 2'b01, {dmarq_out, dmarq_oe})
    dma(1'b1, 5'h00, 16'h0000);
    `CHK("dma_rd_pulse", 1'b0, dma_rd_pulse)
    busy = 0;
  endtask
  task t_proxy;
    wr(5'h16, 8'h10);
    `CHK("selected", 1'b0, selected)
    dma(1'b1, 5'h00, 16'h0000);
    `CHK("dma_released", 3'b000, {dmarq_oe, dma_rd_pulse, rdata_valid})
    dev1_absent = 1;
    rd(5'h17, 8'h00);
    rd(5'h0e, 8'h00);
    rd(5'h11, 8'h04);
    wr(5'h11, 8'h77);
    `CHK("features", 8'h77, features)
    wr(5'h12, 8'h21);
    `CHK("sector_count", 8'h21, sector_count)
    wr(5'h17, 8'h20);
    `CHK("cmd_start", 1'b0, cmd_start)
    wr(5'h17, 8'h90);
    `CHK("cmd_start", 1'b1, cmd_start)
    dev1_absent = 0;
    i_atatf_host_model.cyc(1'b1, 1'b0, 5'h17, 16'h0000);
    `CHK("rdata_valid", 1'b0, rdata_valid)
    dev1_absent = 1;
    wr(5'h0e, 8'h06);
    `CHK("nien_srst", 2'b11, {nien, srst})
  endtask
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    {rst, busy, drq, dev1_absent, dmarq_req, dma_wready, intrq_set} = 7'b1000000;
    {status, error, dma_rdata} = 32'h00000000;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 0;
    t_regs;
    t_dma;
    t_proxy;
    end_of_test;
  end
  // Whole run needs about 65 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 500) begin
      n_fail++;
      end_of_test;
    end
  end
endmodule

/* File: verif/atatf_host_model.sv */
`timescale 1ns/10ps
module atatf_host_model (
  // Clock
  input wire clock,
  // Host cycle pins
  output reg cs0_n = 1'b1,
  output reg cs1_n = 1'b1,
  output reg [2:0] da = 3'h0,
  output reg rd_strobe = 1'b0,
  output reg wr_strobe = 1'b0,
  output reg dmack_n = 1'b1,
  output reg [15:0] host_wdata = 16'h0000
);
  // a = {cs0 asserted, cs1 asserted, da}; callers also issue writes while busy
  task cyc(input rd, input dm, input [4:0] a, input [15:0] d);
    @(negedge clock);
    {cs0_n, cs1_n, da} = {~a[4:3], a[2:0]};
    dmack_n = ~dm;
    rd_strobe = rd;
    wr_strobe = ~rd;
    host_wdata = d;
    @(negedge clock);
    {cs0_n, cs1_n, rd_strobe, wr_strobe, dmack_n} = 5'b11001;
    // Released data shows the inverse, never a stale copy
    host_wdata = ~d;
  endtask
endmodule

/* File: verif/atatf_props.sv */
`timescale 1ns/10ps
module atatf_props #(
  parameter DATA_WIDTH = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Host cycle
  input wire cs0_n,
  input wire cs1_n,
  input wire [2:0] da,
  input wire rd_strobe,
  input wire wr_strobe,
  input wire dmack_n,
  input wire dmarq_oe,
  input wire dmarq_out,
  input wire [DATA_WIDTH-1:0] host_wdata,
  input wire [DATA_WIDTH-1:0] host_rdata,
  input wire rdata_valid,
  // Device state and results
  input wire busy,
  input wire drq,
  input wire [7:0] status,
  input wire dev1_absent,
  input wire intrq_set,
  input wire dma_rd_pulse,
  input wire cmd_start,
  input wire [7:0] cmd_opcode,
  input wire intrq_pending,
  input wire selected,
  input wire [7:0] sector_count,
  input wire [7:0] cyl_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire pri = !cs0_n && cs1_n && dmack_n && selected;
  wire dma = !dmack_n && (rd_strobe || wr_strobe);
  a_cylhi_read: assert property (rd_strobe && pri && da == 3'h5
    |=> rdata_valid && host_rdata[7:0] == ($past(busy) ? $past(status) : $past(cyl_high))) else $error("cylhi read");
  a_status_clear: assert property (rd_strobe && pri && da == 3'h7 && !intrq_set
    |=> !intrq_pending && host_rdata[7:0] == $past(status)) else $error("status read");
  a_cmd_start: assert property (wr_strobe && pri && da == 3'h7 && !busy && !drq
    |=> cmd_start && cmd_opcode == $past(host_wdata[7:0])) else $error("command write");
  a_busy_cmd: assert property (wr_strobe && pri && da == 3'h7 && (busy || drq) && !intrq_set
    |=> !intrq_pending && !cmd_start) else $error("busy command write");
  a_drq_discard: assert property (wr_strobe && pri && da == 3'h2 && !busy && drq
    |=> $stable(sector_count)) else $error("write not discarded");
  a_dma_cs_ignored: assert property (dma && (!cs0_n || !cs1_n)
    |=> !rdata_valid && !dma_rd_pulse) else $error("dma with chip select");
  a_dma_released: assert property (dma && !dmarq_oe |=> !dma_rd_pulse) else $error("released dma");
  a_dma_word: assert property (rd_strobe && !dmack_n && cs0_n && cs1_n && dmarq_oe && dmarq_out && (busy || drq)
    |=> dma_rd_pulse) else $error("dma word missing");
  a_unselected: assert property (rd_strobe && dmack_n && !selected && !dev1_absent
    |=> !rdata_valid) else $error("unselected answer");
  c_cmd: cover property (cmd_start);
  c_dma: cover property (dma_rd_pulse);
  c_proxy: cover property (rdata_valid && !selected);
endmodule

bind atatf_decode atatf_props #(.DATA_WIDTH(DATA_WIDTH)) i_atatf_props (.*);
